// File: src/isio_pkg.sv
package isio_pkg;
  // Instruction word layout
  localparam int ISIO_INSTR_W = 14;
  localparam int ISIO_PTR_W = 16;
  localparam int ISIO_DATA_W = 8;
  localparam int ISIO_OFS_W = 6;
  // Opcodes of the inherent operations
  localparam logic [13:0] ISIO_OP_IDLE = 14'h0000;
  localparam logic [13:0] ISIO_OP_SWRESET = 14'h0001;
  localparam logic [13:0] ISIO_OP_OPTLOAD = 14'h0062;
  // Pointer-update store: 00 0000 0001 1nmm, fixed part in bits 13:3
  localparam logic [10:0] ISIO_STORE_UPD_HI = 11'h003;
  // Indexed store: 11 1111 1nkk kkkk, fixed part in bits 13:7
  localparam logic [6:0] ISIO_STORE_IDX_HI = 7'h7F;
  // Field positions
  localparam int ISIO_UPD_SEL_BIT = 2;
  localparam int ISIO_IDX_SEL_BIT = 6;
  // Update codes
  localparam logic [1:0] ISIO_PRE_INC = 2'h0;
  localparam logic [1:0] ISIO_PRE_DEC = 2'h1;
  localparam logic [1:0] ISIO_POST_INC = 2'h2;
  localparam logic [1:0] ISIO_POST_DEC = 2'h3;
  // Reset values and the unit pointer step
  localparam logic [15:0] ISIO_PTR_RST = 16'h0000;
  localparam logic [7:0] ISIO_OPT_RST = 8'hFF;
  localparam logic [15:0] ISIO_ONE = 16'h0001;

  // Decoded instruction
  typedef struct packed {
    logic is_store;
    logic is_indexed;
    logic sel;
    logic [1:0] upd;
    logic [5:0] ofs;
    logic is_idle;
    logic is_opt;
    logic is_reset;
  } isio_dec_t;

  // Execution states, Gray coded
  typedef enum logic [1:0] {
    ISIO_ST_EXEC = 2'b00,
    ISIO_ST_EXTRA = 2'b01
  } isio_state_t;

  // Data memory write request
  typedef struct packed {
    logic we;
    logic [15:0] addr;
    logic [7:0] data;
    logic prog;
  } isio_mem_t;

  // Whole state of the execution block
  typedef struct packed {
    isio_state_t st;
    logic [1:0][15:0] ptr;
    logic [7:0] opt;
    isio_mem_t mem;
    logic swreset;
    logic ri_clear;
    logic done;
    logic [15:0] pend_ptr;
    logic pend_sel;
  } isio_regs_t;
endpackage

// File: src/isio_decode.sv
`timescale 1ns/1ns
// Combinational instruction classifier
module isio_decode
  import isio_pkg::*;
(
  input wire logic [13:0] i_instr,
  output isio_dec_t o_dec
);
  // Match each supported encoding
  always_comb begin
    o_dec = '0;
    // Pointer-update form
    if (i_instr[13:3] == ISIO_STORE_UPD_HI) begin
      o_dec.is_store = 1'b1;
      o_dec.sel = i_instr[ISIO_UPD_SEL_BIT];
      o_dec.upd = i_instr[1:0];
    end
    // Indexed form
    if (i_instr[13:7] == ISIO_STORE_IDX_HI) begin
      o_dec.is_store = 1'b1;
      o_dec.is_indexed = 1'b1;
      o_dec.sel = i_instr[ISIO_IDX_SEL_BIT];
      o_dec.ofs = i_instr[5:0];
    end
    o_dec.is_idle = (i_instr == ISIO_OP_IDLE);
    o_dec.is_opt = (i_instr == ISIO_OP_OPTLOAD);
    o_dec.is_reset = (i_instr == ISIO_OP_SWRESET);
  end
endmodule

// File: src/isio_exec.sv
`timescale 1ns/1ns
module isio_exec
  import isio_pkg::*;
#(
  parameter int PTR_W = ISIO_PTR_W,
  parameter int DATA_W = ISIO_DATA_W
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_valid, // Instruction word present this cycle
  input wire logic [13:0] i_instr, // Instruction word
  input wire logic [7:0] i_accum, // Accumulator value
  output logic o_ready, // Block can take a new instruction
  output logic o_done, // Instruction finished, pulse
  output logic o_mem_we, // Data write strobe, pulse
  output logic [15:0] o_mem_addr, // Effective write address
  output logic [7:0] o_mem_data, // Write data
  output logic o_mem_prog, // Address lies in program space
  output logic [15:0] o_ptr0, // Pointer 0 value
  output logic [15:0] o_ptr1, // Pointer 1 value
  output logic [7:0] o_option, // Option configuration register
  output logic o_swreset, // Device reset request, pulse
  output logic o_ri_clear, // Clear reset-instruction flag, pulse
  output logic o_status_we // Status flag write enable, always low
);
  // Widths are fixed by the packed state layout; other values are refused here
  // A free width would need a wider state struct in the package as well
  if (PTR_W != ISIO_PTR_W || DATA_W != ISIO_DATA_W) begin : g_bad_width
    $error("isio_exec: unsupported width");
  end

  // Pointer bit that steers an access into program space
  localparam int TOP_BIT = PTR_W - 1;

  // Whole state lives in one packed struct
  isio_regs_t r; // Registered state
  isio_regs_t next_r; // Next state

  // Decoder result and address arithmetic
  isio_dec_t dec; // Decoded instruction
  logic [15:0] cur_ptr; // Pointer selected by the instruction
  logic [15:0] ofs_ext; // Sign-extended offset
  logic [15:0] eff_addr; // Effective address
  logic [15:0] upd_ptr; // Pointer after the store
  logic to_prog; // Effective address lies in program space

  // Opcode classifier; combinational, so decoding costs no cycle
  // It holds no state and therefore needs no reset
  isio_decode u_decode (
    .i_instr(i_instr),
    .o_dec(dec)
  );

  // Address arithmetic, worked out every cycle from the current pointers
  // 16-bit sums wrap by themselves, which gives the modulo range
  always_comb begin
    // Virtual port has no storage: only the pointed location counts
    cur_ptr = r.ptr[dec.sel];
    // Offset field is two's complement
    ofs_ext = {{(PTR_W - ISIO_OFS_W){dec.ofs[ISIO_OFS_W - 1]}}, dec.ofs};
    // Defaults: access at the pointer, pointer kept
    eff_addr = cur_ptr;
    upd_ptr = cur_ptr;
    // Decoder flags the indexed form only for its own encoding
    if (dec.is_indexed) begin
      // Indexed form: offset address, pointer untouched
      eff_addr = 16'(cur_ptr + ofs_ext);
      upd_ptr = cur_ptr;
    end else begin
      // Update form: the two-bit code picks direction and timing
      case (dec.upd)
        ISIO_PRE_INC: begin
          // Step up first, then access the new value
          eff_addr = 16'(cur_ptr + ISIO_ONE);
          upd_ptr = 16'(cur_ptr + ISIO_ONE);
        end
        ISIO_PRE_DEC: begin
          // Step down first, then access the new value
          eff_addr = 16'(cur_ptr - ISIO_ONE);
          upd_ptr = 16'(cur_ptr - ISIO_ONE);
        end
        ISIO_POST_INC: begin
          // Access the old value, then step up
          upd_ptr = 16'(cur_ptr + ISIO_ONE);
        end
        ISIO_POST_DEC: begin
          // Access the old value, then step down
          upd_ptr = 16'(cur_ptr - ISIO_ONE);
        end
        default: begin
          // Unreachable with two bits; pointer kept
          upd_ptr = cur_ptr;
        end
      endcase
    end
  end

  // Top bit of the effective address selects program memory
  // A pre-step that crosses into that half pays the extra cycle as well
  assign to_prog = eff_addr[TOP_BIT];

  // Next-state logic: one copy of the whole state, filled per instruction
  // Branch order is harmless: the supported encodings never overlap
  always_comb begin
    // Hold everything unless an instruction says otherwise
    next_r = r;
    // Pulses last one cycle
    next_r.mem.we = 1'b0;
    next_r.swreset = 1'b0;
    next_r.ri_clear = 1'b0;
    next_r.done = 1'b0;
    // Two states: taking words, or the extra program-space cycle
    case (r.st)
      ISIO_ST_EXEC: begin
        // Words are taken only here; unknown encodings give no completion
        if (i_valid) begin
          if (dec.is_store) begin
            // Write goes to the pointed location, no status touched
            next_r.mem.we = 1'b1;
            // Address and data hold until the next store
            next_r.mem.addr = eff_addr;
            next_r.mem.data = i_accum;
            next_r.mem.prog = to_prog;
            if (to_prog) begin
              // Program space costs a second cycle; pointer updates at its end
              next_r.st = ISIO_ST_EXTRA;
              next_r.pend_ptr = upd_ptr;
              next_r.pend_sel = dec.sel;
            end else begin
              // Data space: pointer steps now and the store is over
              next_r.ptr[dec.sel] = upd_ptr;
              next_r.done = 1'b1;
            end
          end else if (dec.is_opt) begin
            // Accumulator is only read, never written
            // One cycle: the new option value shows after the next edge
            next_r.opt = i_accum;
            next_r.done = 1'b1;
          end else if (dec.is_reset) begin
            // Reset sequencing lies outside; this block only requests it
            next_r.swreset = 1'b1;
            next_r.ri_clear = 1'b1;
            next_r.done = 1'b1;
          end else if (dec.is_idle) begin
            // Completes with nothing changed; the fetch side advances
            next_r.done = 1'b1;
          end
        end
      end

      ISIO_ST_EXTRA: begin
        // Second cycle of a program-space store; new words wait meanwhile
        // Pointer is written back only now, so the stall keeps it consistent
        next_r.ptr[r.pend_sel] = r.pend_ptr;
        next_r.done = 1'b1;
        next_r.st = ISIO_ST_EXEC;
      end

      default: begin
        // Unused code: fall back to taking words
        next_r.st = ISIO_ST_EXEC;
      end
    endcase
  end

  // State register, synchronous reset
  // Reset is sampled like any other input, so one low edge suffices
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      // Pulses, memory request and pending update all clear
      r <= '0;
      r.st <= ISIO_ST_EXEC;
      // Pointers start at the bottom of the space
      r.ptr[0] <= ISIO_PTR_RST;
      r.ptr[1] <= ISIO_PTR_RST;
      // Option register starts with every bit set
      r.opt <= ISIO_OPT_RST;
    end else begin
      // Take the prepared copy whole
      r <= next_r;
    end
  end

  // Handshake output from the state; busy during the extra cycle
  // Combinational on purpose: only the state register feeds it
  assign o_ready = (r.st == ISIO_ST_EXEC);
  // Completion pulse
  assign o_done = r.done;

  // Memory request, all from flip-flops
  // Strobe pulses for one cycle; address and data hold their last value
  assign o_mem_we = r.mem.we;
  assign o_mem_addr = r.mem.addr;
  assign o_mem_data = r.mem.data;
  assign o_mem_prog = r.mem.prog;

  // Pointer values for the rest of the core
  assign o_ptr0 = r.ptr[0];
  assign o_ptr1 = r.ptr[1];

  // Option register
  assign o_option = r.opt;

  // Reset request and flag clear travel together
  assign o_swreset = r.swreset;
  assign o_ri_clear = r.ri_clear;

  // None of these instructions writes status
  assign o_status_we = 1'b0;
endmodule

// File: sim/isio_monitor.sv
`timescale 1ns/1ns
// Port-level checks of the execution block
module isio_monitor
  import isio_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_valid,
  input wire logic [13:0] i_instr,
  input wire logic [7:0] i_accum,
  input wire logic o_ready,
  input wire logic o_done,
  input wire logic o_mem_we,
  input wire logic [15:0] o_mem_addr,
  input wire logic o_mem_prog,
  input wire logic [15:0] o_ptr0,
  input wire logic [15:0] o_ptr1,
  input wire logic [7:0] o_option,
  input wire logic o_swreset,
  input wire logic o_ri_clear,
  input wire logic o_status_we
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // Word accepted at this edge
  sequence s_take(logic [13:0] op); i_valid && o_ready && i_instr == op; endsequence
  // Write that lands in program space
  sequence s_prog; o_mem_we && o_mem_prog; endsequence
  property p_opt; s_take(ISIO_OP_OPTLOAD) |=> o_done && o_option == $past(i_accum); endproperty
  a_opt: assert property (p_opt) else $error("option load wrong");
  property p_rst; s_take(ISIO_OP_SWRESET) |=> o_done && o_swreset && o_ri_clear; endproperty
  a_rst: assert property (p_rst) else $error("soft reset wrong");
  property p_idle; s_take(ISIO_OP_IDLE) |=> o_done && !o_mem_we && $stable(o_ptr0); endproperty
  a_idle: assert property (p_idle) else $error("idle changed state");
  property p_flag; o_status_we == 1'b0; endproperty
  a_flag: assert property (p_flag) else $error("status written");
  property p_pre; s_take(14'h0018) |=> o_mem_we && o_mem_addr == $past(o_ptr0) + 16'h0001;
  endproperty
  a_pre: assert property (p_pre) else $error("pre-increment address");
  property p_post; s_take(14'h001B) ##0 !o_ptr0[15] |=>
    o_ptr0 == $past(o_ptr0) - 16'h0001 && o_mem_addr == $past(o_ptr0); endproperty
  a_post: assert property (p_post) else $error("post-decrement pointer");
  property p_idx; i_valid && o_ready && i_instr[13:6] == {ISIO_STORE_IDX_HI, 1'b1} |=>
    o_mem_addr == $past(o_ptr1) + {{10{$past(i_instr[5])}}, $past(i_instr[5:0])}; endproperty
  a_idx: assert property (p_idx) else $error("indexed address");
  property p_extra; s_prog |-> !o_ready && !o_done ##1 o_done && o_ready; endproperty
  a_extra: assert property (p_extra) else $error("extra cycle missing");
endmodule

// File: sim/tb_top.sv
`timescale 1ns/1ns
// Self-checking bench, one task per scenario
module tb_top;
  import isio_pkg::*;
  logic i_clk, i_reset_n, i_valid;
  logic [13:0] i_instr;
  logic [7:0] i_accum, o_mem_data, o_option;
  logic o_ready, o_done, o_mem_we, o_mem_prog, o_swreset, o_ri_clear, o_status_we;
  logic [15:0] o_mem_addr, o_ptr0, o_ptr1, fc, fa;
  logic [7:0] fd;
  int lat;
  int miscompares = 0;
  int n_compared = 0;
  isio_exec i_dut (.*);
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  task automatic check(input string nm, input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic stop_test();
    if (miscompares == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // One request; first-cycle outputs captured since the write is a pulse
  task automatic issue(input logic [13:0] ins, input logic [7:0] acc);
    @(posedge i_clk);
    i_valid <= 1'b1;
    i_instr <= ins;
    i_accum <= acc;
    @(posedge i_clk);
    i_valid <= 1'b0;
    #1;
    fc = {12'h000, o_mem_we, o_mem_prog, o_swreset, o_ri_clear};
    fa = o_mem_addr;
    fd = o_mem_data;
    lat = 0;
    while (o_done !== 1'b1 && lat < 9) begin
      @(posedge i_clk);
      #1;
      lat++;
    end
  endtask
  task automatic t_reset();
    check("option", {8'h00, o_option}, 16'h00FF);
    check("ptr", o_ptr0 | o_ptr1, 16'h0000);
    check("status", {15'h0000, o_status_we}, 16'h0000);
  endtask
  task automatic t_inherent();
    issue(ISIO_OP_OPTLOAD, 8'h4F);
    check("option", {8'h00, o_option}, 16'h004F);
    check("opt_lat", 16'(lat), 16'h0000);
    issue(ISIO_OP_IDLE, 8'hA5);
    check("idle", fc | {8'h00, o_option}, 16'h004F);
    check("idle_lat", 16'(lat), 16'h0000);
    issue(ISIO_OP_SWRESET, 8'h00);
    check("reset", fc, 16'h0003);
    check("reset_lat", 16'(lat), 16'h0000);
    // Unsupported word: nothing written, no completion within the wait limit
    issue(14'h0064, 8'h77);
    check("refused", fc | {8'h00, o_option}, 16'h004F);
    check("refused_lat", 16'(lat), 16'h0009);
  endtask
  // All four update codes on both pointers, crossing both wrap points
  task automatic t_modes();
    logic [15:0] p, a;
    logic [1:0] m;
    logic [7:0] d;
    for (int n = 0; n < 2; n++) begin
      p = 16'h0000;
      for (int i = 0; i < 4; i++) begin
        m = 2'(i + 3);
        d = 8'(i) + 8'hC0;
        a = (m == ISIO_PRE_INC) ? p + 16'h0001 : (m == ISIO_PRE_DEC) ? p - 16'h0001 : p;
        p = m[0] ? p - 16'h0001 : p + 16'h0001;
        issue({ISIO_STORE_UPD_HI, n[0], m}, d);
        check("addr", fa, a);
        check("ptr", n ? o_ptr1 : o_ptr0, p);
        check("data", {8'h00, fd}, {8'h00, d});
        check("flags", fc, {12'h000, 1'b1, a[15], 2'b00});
        check("lat", 16'(lat), {15'h0000, a[15]});
      end
    end
  endtask
  // Offset limits on pointer 1, which the mode pass leaves at zero
  task automatic t_index();
    int k;
    for (int j = 0; j < 2; j++) begin
      k = j ? 31 : -32;
      issue({ISIO_STORE_IDX_HI, 1'b1, 6'(k)}, 8'h99);
      check("idx_addr", fa, 16'(k));
      check("idx_ptr", o_ptr1, 16'h0000);
      check("idx_lat", 16'(lat), {15'h0000, ~j[0]});
    end
  endtask
  // Mid-run reset after the pointer and option have moved
  task automatic t_rerun();
    issue({ISIO_STORE_UPD_HI, 1'b0, ISIO_POST_INC}, 8'h11);
    check("pre_ptr", o_ptr0, 16'h0001);
    @(posedge i_clk);
    i_reset_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_reset_n <= 1'b1;
    #1;
    check("rst_opt", {8'h00, o_option}, 16'h00FF);
    check("rst_ptr", o_ptr0, 16'h0000);
    issue(ISIO_OP_OPTLOAD, 8'h3C);
    check("rst_load", {8'h00, o_option}, 16'h003C);
    check("rst_lat", 16'(lat), 16'h0000);
  endtask
  initial begin
    #20000;
    miscompares++;
    stop_test();
  end
  initial begin
    i_reset_n = 1'b0;
    i_valid = 1'b0;
    i_instr = 14'h0000;
    i_accum = 8'h00;
    repeat (5) @(posedge i_clk);
    i_reset_n <= 1'b1;
    #1;
    t_reset();
    t_inherent();
    t_modes();
    t_index();
    t_rerun();
    stop_test();
  end
endmodule
bind isio_exec isio_monitor u_mon (.*);
